// ===== common/serial_pkg.sv
package serial_pkg;
	// register map
	localparam logic [7:0] SERIAL_CONTROL_ADDR = 8'h98;
	localparam logic [7:0] SERIAL_DATA_BUFFER_ADDR = 8'h99;
	localparam logic [7:0] SERIAL_CONTROL_RST  = 8'h00;
	localparam logic [7:0] SERIAL_DATA_BUFFER_RST  = 8'h00;
	// serial_control fields
	localparam int MSEL_HI_BIT = 7;
	localparam int MSEL_LO_BIT = 6;
	localparam int MPF_BIT     = 5;
	localparam int RXEN_BIT    = 4;
	localparam int TX9_BIT     = 3;
	localparam int RX9_BIT     = 2;
	localparam int TXF_BIT     = 1;
	localparam int RXF_BIT     = 0;
	// mode codes, high select bit first
	localparam logic [1:0] MODE_SHIFT = 2'h0;
	localparam logic [1:0] MODE_VAR8  = 2'h1;
	localparam logic [1:0] MODE_FIX9  = 2'h2;
	localparam logic [1:0] MODE_VAR9  = 2'h3;
	// timing
	localparam int TICKS_PER_BIT = 16;
	localparam logic [3:0] SHIFT_LAST = 4'h7;
	localparam logic [3:0] STOP_IDX8  = 4'h9;
	localparam logic [3:0] STOP_IDX9  = 4'hA;
endpackage

// ===== hdl/bit_timer.sv
`timescale 1ns/1ps
module bit_timer #(
	parameter int TICKS = 16
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// control
	input  wire logic restart,
	input  wire logic tick,
	// bit phase pulses
	output logic      mid,
	output logic      last
);
	localparam int W = $clog2(TICKS);
	localparam logic [W-1:0] MID_CNT  = W'(TICKS / 2 - 1);
	localparam logic [W-1:0] LAST_CNT = W'(TICKS - 1);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	always_comb
	begin
		cnt_nxt = cnt_r;
		if (restart)
			cnt_nxt = '0;
		else if (tick)
			cnt_nxt = cnt_r + W'(1);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	assign mid  = tick && !restart && cnt_r == MID_CNT;
	assign last = tick && !restart && cnt_r == LAST_CNT;
endmodule

// ===== hdl/serial_port.sv
// What this block does
// - Async transmitter and receiver run independently; send and receive overlap.
// - One-byte receive buffer; a new byte overwrites an unread one.
// - Data buffer address: write loads transmit, read returns receive reg.
// - Serial control is bit addressable and resets to all zeros.
// - Mode bits: 00 shift, 01 8-bit variable, 10 9-bit fixed, 11 9-bit var.
// - 9-bit modes with filter set: no receive flag if ninth bit is 0.
// - 8-bit variable mode with filter set: flag only on valid stop bit.
// - Receive enable gates the start of any new reception.
// - 9-bit modes send the transmit ninth bit field as the ninth bit.
// - Received ninth bit, or stop bit in 8-bit mode, goes to rx ninth.
// - Tx done set after 8th bit or at stop start; software clears.
// - Rx flag set after 8th bit or mid stop bit; software clears.
// - Shift mode: data on receive pin, transmit pin gives shift clock.
// - Shift mode: buffer write shifts eight bits out, LSB first.
// - Shift mode: receive starts when enable is 1 and rx flag is 0.
// - 8-bit frame: start 0, eight data LSB first, stop 1.
// - 9-bit frame adds ninth bit; fixed rate core/32 or core/16.
// - Variable modes: bit is sixteen timer ticks, rx/tx source selectable.
`timescale 1ns/1ps
module serial_port (
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RST_N,
	// register port
	input  wire logic [7:0] SFR_ADDR,
	input  wire logic [7:0] SFR_WDATA,
	input  wire logic       SFR_WR,
	input  wire logic       SFR_RD,
	input  wire logic       SFR_BIT_WR,
	input  wire logic [2:0] SFR_BIT_SEL,
	input  wire logic       SFR_BIT_VAL,
	output logic      [7:0] SFR_RDATA,
	// rate selection
	input  wire logic       BAUD_DOUBLE,
	input  wire logic       RX_TICK_SOURCE_SEL,
	input  wire logic       TX_TICK_SOURCE_SEL,
	input  wire logic       TMR1_TICK,
	input  wire logic       TMR2_TICK,
	// serial pins
	input  wire logic       RXD_IN,
	output logic            RXD_OUT,
	output logic            RXD_OE,
	output logic            TXD
);
	typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tx_e;
	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA  = 4'b0100,
		RX_STOP  = 4'b1000
	} rx_e;
	typedef enum logic [2:0] {
		M0_IDLE = 3'b001,
		M0_TX   = 3'b010,
		M0_RX   = 3'b100
	} m0_e;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = a == r;
	endfunction

	// register state
	logic [7:0] serial_control_r;
	logic [7:0] serial_control_nxt;
	logic [7:0] rx_buf_r;
	logic [7:0] rx_buf_nxt;
	logic [7:0] rdata_nxt;
	// pin sync and rate
	logic       rxd_s1_r;
	logic       rxd_s2_r;
	logic       rxd_s3_r;
	logic       div2_r;
	// async tx
	tx_e        tx_state_r;
	tx_e        tx_state_nxt;
	logic [10:0] tx_sh_r;
	logic [10:0] tx_sh_nxt;
	logic [3:0] tx_cnt_r;
	logic [3:0] tx_cnt_nxt;
	// async rx
	rx_e        rx_state_r;
	rx_e        rx_state_nxt;
	logic [8:0] rx_sh_r;
	logic [8:0] rx_sh_nxt;
	logic [3:0] rx_cnt_r;
	logic [3:0] rx_cnt_nxt;
	// shift mode
	m0_e        m0_state_r;
	m0_e        m0_state_nxt;
	logic [7:0] m0_sh_r;
	logic [7:0] m0_sh_nxt;
	logic [3:0] m0_cnt_r;
	logic [3:0] m0_cnt_nxt;
	logic       m0_ph_r;
	logic       m0_ph_nxt;
	// events and pins
	logic       ti_set;
	logic       tx_stop_set;
	logic       ri_set;
	logic       rx_load;
	logic [7:0] rx_data;
	logic       rb8_load;
	logic       rb8_val;
	logic       txd_nxt;
	logic       rxd_out_nxt;
	logic       rxd_oe_nxt;

	logic [1:0] mode;
	logic       mode0;
	logic       nine;
	logic       serial_data_buffer_wr;
	logic       fix_tick;
	logic       tx_tick;
	logic       rx_tick;
	logic       tx_restart;
	logic       rx_restart;
	logic       tx_mid;
	logic       tx_last;
	logic       rx_mid;
	logic       rx_last;
	logic       rx_fall;
	logic       accept;

	assign mode  = {serial_control_r[serial_pkg::MSEL_HI_BIT],
		serial_control_r[serial_pkg::MSEL_LO_BIT]};
	assign mode0 = mode == serial_pkg::MODE_SHIFT;
	assign nine  = mode[1];
	assign serial_data_buffer_wr = SFR_WR && hit(SFR_ADDR, serial_pkg::SERIAL_DATA_BUFFER_ADDR);
	// fixed rate: 16 ticks per bit, tick every 1 or 2 clocks
	assign fix_tick = BAUD_DOUBLE || div2_r;
	// per-direction tick source in variable modes
	assign tx_tick = (mode == serial_pkg::MODE_FIX9) ? fix_tick :
		(TX_TICK_SOURCE_SEL ? TMR2_TICK : TMR1_TICK);
	assign rx_tick = (mode == serial_pkg::MODE_FIX9) ? fix_tick :
		(RX_TICK_SOURCE_SEL ? TMR2_TICK : TMR1_TICK);
	// s1 is read only by s2; edge uses s2 and s3
	assign rx_fall = rxd_s3_r && !rxd_s2_r;

	bit_timer #(.TICKS(serial_pkg::TICKS_PER_BIT)) u_tx_timer (
		.clk     (CLK),
		.rst_n   (RST_N),
		.restart (tx_restart),
		.tick    (tx_tick),
		.mid     (tx_mid),
		.last    (tx_last)
	);

	bit_timer #(.TICKS(serial_pkg::TICKS_PER_BIT)) u_rx_timer (
		.clk     (CLK),
		.rst_n   (RST_N),
		.restart (rx_restart),
		.tick    (rx_tick),
		.mid     (rx_mid),
		.last    (rx_last)
	);

	// register file; hardware sets win over software writes
	always_comb
	begin
		serial_control_nxt   = serial_control_r;
		rx_buf_nxt = rx_buf_r;
		rdata_nxt  = SFR_RDATA;
		if (SFR_WR && hit(SFR_ADDR, serial_pkg::SERIAL_CONTROL_ADDR))
			serial_control_nxt = SFR_WDATA;
		if (SFR_BIT_WR)
			serial_control_nxt[SFR_BIT_SEL] = SFR_BIT_VAL;
		if (ti_set)
			serial_control_nxt[serial_pkg::TXF_BIT] = 1'b1;
		if (ri_set)
			serial_control_nxt[serial_pkg::RXF_BIT] = 1'b1;
		if (rb8_load)
			serial_control_nxt[serial_pkg::RX9_BIT] = rb8_val;
		if (rx_load)
			rx_buf_nxt = rx_data;
		if (SFR_RD)
		begin
			if (hit(SFR_ADDR, serial_pkg::SERIAL_CONTROL_ADDR))
				rdata_nxt = serial_control_r;
			else if (hit(SFR_ADDR, serial_pkg::SERIAL_DATA_BUFFER_ADDR))
				rdata_nxt = rx_buf_r;
			else
				rdata_nxt = 8'h00;
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			serial_control_r    <= serial_pkg::SERIAL_CONTROL_RST;
			rx_buf_r  <= serial_pkg::SERIAL_DATA_BUFFER_RST;
			SFR_RDATA <= 8'h00;
			rxd_s1_r  <= 1'b1;
			rxd_s2_r  <= 1'b1;
			rxd_s3_r  <= 1'b1;
			div2_r    <= 1'b0;
		end
		else
		begin
			serial_control_r    <= serial_control_nxt;
			rx_buf_r  <= rx_buf_nxt;
			SFR_RDATA <= rdata_nxt;
			rxd_s1_r  <= RXD_IN;
			rxd_s2_r  <= rxd_s1_r;
			rxd_s3_r  <= rxd_s2_r;
			div2_r    <= !div2_r;
		end
	end

	// tx apart from rx
	// async transmitter, independent of the receiver
	always_comb
	begin
		tx_state_nxt = tx_state_r;
		tx_sh_nxt    = tx_sh_r;
		tx_cnt_nxt   = tx_cnt_r;
		tx_restart   = 1'b0;
		tx_stop_set  = 1'b0;
		case (tx_state_r)
			TX_IDLE:
				// start 0, data LSB first, ninth or stop, stop 1
				if (serial_data_buffer_wr && !mode0)
				begin
					tx_state_nxt = TX_SEND;
					tx_restart   = 1'b1;
					tx_cnt_nxt   = 4'h0;
					tx_sh_nxt = {1'b1,
						nine ? serial_control_r[serial_pkg::TX9_BIT] : 1'b1,
						SFR_WDATA, 1'b0};
				end
			TX_SEND:
				// writes while busy are dropped; no queue behind the shifter
				if (tx_last)
				begin
					tx_sh_nxt  = {1'b1, tx_sh_r[10:1]};
					tx_cnt_nxt = tx_cnt_r + 4'h1;
					// flag as the stop bit reaches the line
					if (tx_cnt_r == (nine ? serial_pkg::STOP_IDX9 :
						serial_pkg::STOP_IDX8) - 4'h1)
						tx_stop_set = 1'b1;
					if (tx_cnt_r == (nine ? serial_pkg::STOP_IDX9 :
						serial_pkg::STOP_IDX8))
						tx_state_nxt = TX_IDLE;
				end
			default:
				tx_state_nxt = TX_IDLE;
		endcase
		if (mode0)
			tx_state_nxt = TX_IDLE;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			tx_state_r <= TX_IDLE;
			tx_sh_r    <= '1;
			tx_cnt_r   <= 4'h0;
		end
		else
		begin
			tx_state_r <= tx_state_nxt;
			tx_sh_r    <= tx_sh_nxt;
			tx_cnt_r   <= tx_cnt_nxt;
		end
	end

	// async receiver
	always_comb
	begin
		rx_state_nxt = rx_state_r;
		rx_sh_nxt    = rx_sh_r;
		rx_cnt_nxt   = rx_cnt_r;
		rx_restart   = 1'b0;
		accept       = 1'b0;
		case (rx_state_r)
			RX_IDLE:
				if (!mode0 && serial_control_r[serial_pkg::RXEN_BIT] && rx_fall)
				begin
					rx_state_nxt = RX_START;
					rx_restart   = 1'b1;
				end
			RX_START:
				if (rx_mid)
				begin
					rx_state_nxt = rxd_s2_r ? RX_IDLE : RX_DATA;
					rx_cnt_nxt   = 4'h0;
				end
			RX_DATA:
				if (rx_mid)
				begin
					rx_sh_nxt  = {rxd_s2_r, rx_sh_r[8:1]};
					rx_cnt_nxt = rx_cnt_r + 4'h1;
					if (rx_cnt_r == (nine ? 4'h8 : serial_pkg::SHIFT_LAST))
						rx_state_nxt = RX_STOP;
				end
			RX_STOP:
				if (rx_mid)
				begin
					rx_state_nxt = RX_IDLE;
					accept = !serial_control_r[serial_pkg::MPF_BIT] ||
						(nine ? rx_sh_r[8] : rxd_s2_r);
				end
			default:
				rx_state_nxt = RX_IDLE;
		endcase
		if (mode0)
			rx_state_nxt = RX_IDLE;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rx_state_r <= RX_IDLE;
			rx_sh_r    <= 9'h000;
			rx_cnt_r   <= 4'h0;
		end
		else
		begin
			rx_state_r <= rx_state_nxt;
			rx_sh_r    <= rx_sh_nxt;
			rx_cnt_r   <= rx_cnt_nxt;
		end
	end

	// shift-register mode, clock phase at core/2
	always_comb
	begin
		m0_state_nxt = m0_state_r;
		m0_sh_nxt    = m0_sh_r;
		m0_cnt_nxt   = m0_cnt_r;
		m0_ph_nxt    = !m0_ph_r;
		case (m0_state_r)
			M0_IDLE:
			begin
				m0_ph_nxt  = 1'b0;
				m0_cnt_nxt = 4'h0;
				// write starts an eight-bit shift out
				if (mode0 && serial_data_buffer_wr)
				begin
					m0_state_nxt = M0_TX;
					m0_sh_nxt    = SFR_WDATA;
				end
				// receive when enabled and flag clear
				else if (mode0 && serial_control_r[serial_pkg::RXEN_BIT] &&
					!serial_control_r[serial_pkg::RXF_BIT])
					m0_state_nxt = M0_RX;
			end
			M0_TX, M0_RX:
				// sample/shift at end of clock-high half
				if (m0_ph_r)
				begin
					m0_cnt_nxt = m0_cnt_r + 4'h1;
					m0_sh_nxt  = (m0_state_r == M0_RX) ?
						{rxd_s2_r, m0_sh_r[7:1]} : {1'b1, m0_sh_r[7:1]};
					if (m0_cnt_r == serial_pkg::SHIFT_LAST)
						m0_state_nxt = M0_IDLE;
				end
			default:
				m0_state_nxt = M0_IDLE;
		endcase
		if (!mode0)
			m0_state_nxt = M0_IDLE;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			m0_state_r <= M0_IDLE;
			m0_sh_r    <= 8'h00;
			m0_cnt_r   <= 4'h0;
			m0_ph_r    <= 1'b0;
		end
		else
		begin
			m0_state_r <= m0_state_nxt;
			m0_sh_r    <= m0_sh_nxt;
			m0_cnt_r   <= m0_cnt_nxt;
			m0_ph_r    <= m0_ph_nxt;
		end
	end

	// completion events and pins
	always_comb
	begin
		logic m0_end;
		m0_end  = m0_ph_r && m0_cnt_r == serial_pkg::SHIFT_LAST;
		// shift mode done after eighth bit
		ti_set  = tx_stop_set || (m0_end && m0_state_r == M0_TX);
		rx_load = accept || (m0_end && m0_state_r == M0_RX);
		ri_set  = rx_load;
		rx_data = accept ? (nine ? rx_sh_r[7:0] : rx_sh_r[8:1]) :
			{rxd_s2_r, m0_sh_r[7:1]};
		rb8_load = accept;
		rb8_val  = nine ? rx_sh_r[8] : rxd_s2_r;
		// shift mode: clock on transmit pin, data on receive pin
		if (m0_state_nxt != M0_IDLE)
			txd_nxt = m0_ph_nxt;
		else if (tx_state_nxt == TX_SEND)
			txd_nxt = tx_sh_nxt[0];
		else
			txd_nxt = 1'b1;
		rxd_oe_nxt  = m0_state_nxt == M0_TX;
		rxd_out_nxt = rxd_oe_nxt ? m0_sh_nxt[0] : 1'b1;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			TXD     <= 1'b1;
			RXD_OUT <= 1'b1;
			RXD_OE  <= 1'b0;
		end
		else
		begin
			TXD     <= txd_nxt;
			RXD_OUT <= rxd_out_nxt;
			RXD_OE  <= rxd_oe_nxt;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_tx_done_m0: assert property (
		m0_state_r == M0_TX && m0_ph_r && m0_cnt_r == serial_pkg::SHIFT_LAST
		|=> serial_control_r[serial_pkg::TXF_BIT])
		else $error("tx done not set after shift");
	a_rx_buf_separate: assert property (
		serial_data_buffer_wr && !rx_load |=> $stable(rx_buf_r))
		else $error("buffer write disturbed receive register");
	a_rx_overwrite: assert property (
		rx_load && serial_control_r[serial_pkg::RXF_BIT] |=> rx_buf_r == $past(rx_data))
		else $error("held byte not overwritten");
	a_rx_enable_gate: assert property (
		rx_state_r == RX_IDLE && !serial_control_r[serial_pkg::RXEN_BIT]
		|=> rx_state_r == RX_IDLE)
		else $error("reception started while disabled");
	a_filter_nine: assert property (
		rx_state_r == RX_STOP && rx_mid && nine &&
		serial_control_r[serial_pkg::MPF_BIT] && !rx_sh_r[8] |-> !ri_set)
		else $error("filtered frame raised receive flag");
	a_filter_stop: assert property (
		rx_state_r == RX_STOP && rx_mid && mode == serial_pkg::MODE_VAR8 &&
		serial_control_r[serial_pkg::MPF_BIT] && !rxd_s2_r |-> !ri_set)
		else $error("bad stop raised receive flag");
	a_tx_ninth_load: assert property (
		tx_state_r == TX_IDLE && serial_data_buffer_wr && !mode0 && nine
		|=> tx_sh_r[9] == $past(serial_control_r[serial_pkg::TX9_BIT]))
		else $error("ninth bit not loaded");
	a_rb8_stop: assert property (
		accept && !nine |=> serial_control_r[serial_pkg::RX9_BIT] == $past(rxd_s2_r))
		else $error("stop bit not latched");
	a_m0_lsb_first: assert property (
		m0_state_r == M0_IDLE && mode0 && serial_data_buffer_wr
		|=> RXD_OE && RXD_OUT == $past(SFR_WDATA[0]) && !TXD)
		else $error("shift out not LSB first");
	a_start_reject: assert property (
		rx_state_r == RX_START && rx_mid && rxd_s2_r
		|=> rx_state_r == RX_IDLE)
		else $error("false start not rejected");
	c_tx_async: cover property (tx_state_r == TX_SEND && ti_set);
	c_rx_async: cover property (accept);
	c_rx_filtered: cover property (rx_state_r == RX_STOP && rx_mid && !accept);
	c_rx_shift: cover property (m0_state_r == M0_RX ##1 m0_state_r == M0_IDLE);
endmodule

// ===== sim/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
	// clock
	input  wire logic clk,
	// serial lines
	input  wire logic txd,
	input  wire logic line,
	output logic      rxd
);
	logic [7:0] cap_data;
	logic       cap_ninth;
	logic       cap_start;
	logic       cap_stop;

	initial
	begin
		rxd = 1'h1;
	end

	task automatic put(input logic v, input int n);
		rxd = v;
		repeat (n) @(negedge clk);
	endtask

	// start, data lsb first, ninth, stop
	task automatic send_frame(input logic [7:0] d, input logic nine,
		input logic nb, input logic stp, input int bitc);
		@(negedge clk);
		put(1'h0, bitc);
		for (int i = 0; i < 8; i++)
			put(d[i], bitc);
		if (nine)
			put(nb, bitc);
		put(stp, bitc);
		rxd = 1'h1;
	endtask

	// sample each bit near its middle
	task automatic catch_frame(input logic nine, input int bitc);
		@(negedge txd);
		repeat (bitc / 2) @(negedge clk);
		cap_start = txd;
		for (int i = 0; i < 8; i++)
		begin
			repeat (bitc) @(negedge clk);
			cap_data[i] = txd;
		end
		if (nine)
		begin
			repeat (bitc) @(negedge clk);
			cap_ninth = txd;
		end
		repeat (bitc) @(negedge clk);
		cap_stop = txd;
	endtask

	// data on the shared pin, taken as the clock rises
	task automatic catch_shift;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge txd);
			cap_data[i] = line;
		end
	endtask

	// bit 0 waits before the first clock; later bits
	// change just after each clock rise, as a shift register does
	task automatic shift_send(input logic [7:0] d);
		rxd = d[0];
		for (int i = 1; i < 8; i++)
		begin
			@(posedge txd);
			@(negedge clk);
			rxd = d[i];
		end
		@(posedge txd);
		@(negedge clk);
		rxd = 1'h1;
	endtask
endmodule

// ===== sim/tb_serial_port.sv
`timescale 1ns/1ps
module tb_serial_port;
	logic       clk;
	logic       rst_n;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr_s;
	logic       rd_s;
	logic       bwr;
	logic [2:0] bsel;
	logic       bval;
	logic [7:0] rdata;
	logic       bd;
	logic       rsel;
	logic       tsel;
	logic       t2;
	logic       rxd_out;
	logic       rxd_oe;
	logic       txd;
	logic       peer_rxd;
	wire        line;
	int         bad_count = 0;
	int         cmp_count = 0;
	int         cyc = 0;

	// wire level of the shared data pin
	assign line = rxd_oe ? rxd_out : peer_rxd;

	serial_port i_dut (
		.CLK(clk), .RST_N(rst_n), .SFR_ADDR(addr), .SFR_WDATA(wdata),
		.SFR_WR(wr_s), .SFR_RD(rd_s), .SFR_BIT_WR(bwr),
		.SFR_BIT_SEL(bsel), .SFR_BIT_VAL(bval), .SFR_RDATA(rdata),
		.BAUD_DOUBLE(bd), .RX_TICK_SOURCE_SEL(rsel),
		.TX_TICK_SOURCE_SEL(tsel), .TMR1_TICK(1'h1), .TMR2_TICK(t2),
		.RXD_IN(line), .RXD_OUT(rxd_out), .RXD_OE(rxd_oe), .TXD(txd)
	);

	serial_peer i_peer (
		.clk(clk), .txd(txd), .line(line), .rxd(peer_rxd)
	);

	initial
	begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// second tick source pulses every other cycle
	always @(negedge clk)
		t2 <= ~t2;

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			bad_count++;
			results();
		end
	end

	task automatic results;
		$display("compares=%0d mismatches=%0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_s = 1'h1;
		@(negedge clk);
		wr_s = 1'h0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		addr = a;
		rd_s = 1'h1;
		@(negedge clk);
		rd_s = 1'h0;
		chk(rdata, exp);
	endtask

	task automatic bw(input logic [2:0] s, input logic v);
		@(negedge clk);
		bsel = s;
		bval = v;
		bwr = 1'h1;
		@(negedge clk);
		bwr = 1'h0;
	endtask

	// one frame each way at once, then flags, ninth bit and buffer
	task automatic async_case(input logic [7:0] ctl, input logic b,
		input logic sel, input int bitc, input logic [7:0] txb,
		input logic [7:0] rxb, input logic nin, input logic stp,
		input logic exp);
		logic rx9;
		rx9 = exp ? (ctl[7] ? nin : stp) : 1'h0;
		bd = b;
		rsel = sel;
		tsel = sel;
		wr(serial_pkg::SERIAL_CONTROL_ADDR, ctl);
		fork
			i_peer.send_frame(rxb, ctl[7], nin, stp, bitc);
			i_peer.catch_frame(ctl[7], bitc);
			wr(serial_pkg::SERIAL_DATA_BUFFER_ADDR, txb);
		join
		repeat (6) @(negedge clk);
		chk(i_peer.cap_data, txb);
		chk({7'h00, i_peer.cap_start}, 8'h00);
		chk({7'h00, i_peer.cap_stop}, 8'h01);
		if (ctl[7])
			chk({7'h00, i_peer.cap_ninth}, {7'h00, ctl[3]});
		rd_chk(serial_pkg::SERIAL_CONTROL_ADDR, {ctl[7:3], rx9, 1'h1, exp});
		if (exp)
			rd_chk(serial_pkg::SERIAL_DATA_BUFFER_ADDR, rxb);
		$display("async case ctl=%h done", ctl);
	endtask

	initial
	begin
		rst_n = 1'h0;
		addr = 8'h00;
		wdata = 8'h00;
		wr_s = 1'h0;
		rd_s = 1'h0;
		bwr = 1'h0;
		bsel = 3'h0;
		bval = 1'h0;
		bd = 1'h0;
		rsel = 1'h0;
		tsel = 1'h0;
		t2 = 1'h0;
		repeat (6) @(negedge clk);
		rst_n = 1'h1;
		rd_chk(serial_pkg::SERIAL_CONTROL_ADDR, 8'h00);
		rd_chk(8'h97, 8'h00);
		bw(3'(serial_pkg::RXEN_BIT), 1'h1);
		rd_chk(serial_pkg::SERIAL_CONTROL_ADDR, 8'h10);
		$display("register test done");
		async_case(8'h50, 1'h0, 1'h0, 16, 8'hA5, 8'h3C, 1'h0, 1'h1, 1'h1);
		async_case(8'h70, 1'h0, 1'h0, 16, 8'h5A, 8'h81, 1'h0, 1'h0, 1'h0);
		async_case(8'h98, 1'h0, 1'h0, 32, 8'hC3, 8'h7E, 1'h1, 1'h1, 1'h1);
		async_case(8'h98, 1'h1, 1'h0, 16, 8'h0F, 8'hE1, 1'h0, 1'h1, 1'h1);
		async_case(8'hF0, 1'h0, 1'h1, 32, 8'h96, 8'h42, 1'h0, 1'h1, 1'h0);
		async_case(8'hF8, 1'h0, 1'h1, 32, 8'h69, 8'hB7, 1'h1, 1'h1, 1'h1);
		async_case(8'h40, 1'h0, 1'h0, 16, 8'h33, 8'h55, 1'h0, 1'h1, 1'h0);
		wr(serial_pkg::SERIAL_CONTROL_ADDR, 8'h50);
		i_peer.put(1'h0, 3);
		i_peer.put(1'h1, 200);
		rd_chk(serial_pkg::SERIAL_CONTROL_ADDR, 8'h50);
		i_peer.send_frame(8'h11, 1'h0, 1'h0, 1'h1, 16);
		i_peer.send_frame(8'h22, 1'h0, 1'h0, 1'h1, 16);
		repeat (6) @(negedge clk);
		rd_chk(serial_pkg::SERIAL_DATA_BUFFER_ADDR, 8'h22);
		$display("overrun and glitch test done");
		wr(serial_pkg::SERIAL_CONTROL_ADDR, 8'h00);
		fork
			i_peer.catch_shift();
			wr(serial_pkg::SERIAL_DATA_BUFFER_ADDR, 8'h6B);
		join
		repeat (4) @(negedge clk);
		chk(i_peer.cap_data, 8'h6B);
		rd_chk(serial_pkg::SERIAL_CONTROL_ADDR, 8'h02);
		fork
			i_peer.shift_send(8'hC4);
			bw(3'(serial_pkg::RXEN_BIT), 1'h1);
		join
		repeat (10) @(negedge clk);
		rd_chk(serial_pkg::SERIAL_DATA_BUFFER_ADDR, 8'hC4);
		rd_chk(serial_pkg::SERIAL_CONTROL_ADDR, 8'h13);
		$display("shift mode test done");
		results();
	end
endmodule
